/* dhbdc_top.sv */
// dual bridge drive control: input decode, chopping, decay, faults, sleep and wake
// assumes all pins are synchronous to sys_clk; rst is the supply undervoltage reset
`timescale 1ns/10ps
module dhbdc_top #(
  parameter int OCP_RETRY_CYC = dhbdc_pkg::OCP_RETRY_CYC,
  parameter int SLEEP_ENTRY_CYC = dhbdc_pkg::SLEEP_ENTRY_CYC,
  parameter int WAKE_UP_CYC = dhbdc_pkg::WAKE_UP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire dhbdc_pkg::dhbdc_tri_s bridge_a_in_first,
  input wire dhbdc_pkg::dhbdc_tri_s bridge_a_in_second,
  input wire logic bridge_b_in_first,
  input wire logic bridge_b_in_second,
  input wire logic sleep_ctrl_n,
  input wire logic [1:0] chop_trip,
  input wire logic [1:0] current_near_zero,
  input wire logic [1:0] fet_limit_high,
  input wire logic [1:0] fet_limit_low,
  input wire logic thermal_shutdown,
  output dhbdc_pkg::dhbdc_bridge_s bridge_a_out,
  output dhbdc_pkg::dhbdc_bridge_s bridge_b_out,
  output dhbdc_pkg::dhbdc_pin_s error_indicator_n,
  output logic internal_regulator_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [dhbdc_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  localparam int W = dhbdc_pkg::CNT_W;
  localparam logic [W-1:0] OFF_LAST = W'(dhbdc_pkg::CHOP_OFF_CYC - 1);
  localparam logic [W-1:0] FAST_LAST = W'(dhbdc_pkg::CHOP_FAST_CYC - 1);
  localparam logic [W-1:0] BLANK_CYC = W'(dhbdc_pkg::SENSE_BLANK_CYC);
  localparam logic [W-1:0] DEG_LAST = W'(dhbdc_pkg::OCP_DEG_CYC - 1);
  localparam logic [W-1:0] RETRY_LAST = W'(OCP_RETRY_CYC - 1);
  localparam logic [W-1:0] SLEEP_LAST = W'(SLEEP_ENTRY_CYC - 1);
  localparam logic [W-1:0] WAKE_LAST = W'(WAKE_UP_CYC - 1);

  dhbdc_pkg::dhbdc_mode_e mode_q;
  dhbdc_pkg::dhbdc_mode_e mode_d;
  logic [W-1:0] mcnt_q;
  logic [W-1:0] mcnt_d;
  logic parallel_q;
  logic parallel_d;
  logic tsd_q;
  logic tsd_dly_q;
  logic chop_en_q;
  dhbdc_pkg::dhbdc_cmd_e cmd_q [dhbdc_pkg::NUM_BR];
  dhbdc_pkg::dhbdc_cmd_e cmd_d [dhbdc_pkg::NUM_BR];
  dhbdc_pkg::dhbdc_cmd_e cmd_in [dhbdc_pkg::NUM_BR];
  dhbdc_pkg::dhbdc_chop_e chop_q [dhbdc_pkg::NUM_BR];
  dhbdc_pkg::dhbdc_chop_e chop_d [dhbdc_pkg::NUM_BR];
  logic [W-1:0] tmr_q [dhbdc_pkg::NUM_BR];
  logic [W-1:0] tmr_d [dhbdc_pkg::NUM_BR];
  logic ocp_q [dhbdc_pkg::NUM_BR];
  logic ocp_d [dhbdc_pkg::NUM_BR];
  logic [W-1:0] ocnt_q [dhbdc_pkg::NUM_BR];
  logic [W-1:0] ocnt_d [dhbdc_pkg::NUM_BR];
  logic [1:0] trip_eff;
  logic [1:0] hold;
  logic [1:0] br_off;
  logic run;
  logic a_any_hiz;
  logic a_all_hiz;
  logic fault_any;
  dhbdc_pkg::dhbdc_bridge_s out_d [dhbdc_pkg::NUM_BR];

  // bridge a tri-level inputs and source selection
  assign a_any_hiz = bridge_a_in_first.hiz | bridge_a_in_second.hiz;
  assign a_all_hiz = bridge_a_in_first.hiz & bridge_a_in_second.hiz;
  assign cmd_in[dhbdc_pkg::BR_B] = dhbdc_pkg::decode(bridge_b_in_first, bridge_b_in_second);
  assign cmd_in[dhbdc_pkg::BR_A] = dhbdc_pkg::decode(bridge_a_in_first.lvl,
                                                     bridge_a_in_second.lvl);
  assign hold[dhbdc_pkg::BR_A] = a_any_hiz & ~parallel_q;
  assign hold[dhbdc_pkg::BR_B] = 1'b0;
  // shared sense resistor in parallel mode: either comparator trips the shared state
  assign trip_eff[dhbdc_pkg::BR_A] = chop_trip[dhbdc_pkg::BR_A];
  assign trip_eff[dhbdc_pkg::BR_B] = parallel_q ? |chop_trip : chop_trip[dhbdc_pkg::BR_B];
  assign run = (mode_q == dhbdc_pkg::MD_RUN) & ~tsd_q;
  // in parallel mode an overcurrent on either half stops the pair
  assign br_off[dhbdc_pkg::BR_A] = ~run | ocp_q[dhbdc_pkg::BR_A] |
                                   (parallel_q & ocp_q[dhbdc_pkg::BR_B]);
  assign br_off[dhbdc_pkg::BR_B] = ~run | ocp_q[dhbdc_pkg::BR_B] |
                                   (parallel_q & ocp_q[dhbdc_pkg::BR_A]);
  assign fault_any = ocp_q[dhbdc_pkg::BR_A] | ocp_q[dhbdc_pkg::BR_B] | tsd_q | tsd_dly_q;

  // sleep, wake and parallel-mode sampling
  always_comb
  begin
    mode_d = mode_q;
    mcnt_d = mcnt_q + W'(1);
    parallel_d = parallel_q;
    unique case (mode_q)
      dhbdc_pkg::MD_SLEEP:
      begin
        mcnt_d = '0;
        if (sleep_ctrl_n)
        begin
          mode_d = dhbdc_pkg::MD_WAKE;
          parallel_d = a_all_hiz;
        end
      end
      dhbdc_pkg::MD_WAKE:
      begin
        if (!sleep_ctrl_n)
        begin
          mode_d = dhbdc_pkg::MD_SLEEP;
        end
        else if (mcnt_q == WAKE_LAST)
        begin
          mode_d = dhbdc_pkg::MD_RUN;
        end
      end
      dhbdc_pkg::MD_RUN:
      begin
        mcnt_d = '0;
        if (!sleep_ctrl_n)
        begin
          mode_d = dhbdc_pkg::MD_DOZE;
        end
      end
      dhbdc_pkg::MD_DOZE:
      begin
        if (sleep_ctrl_n)
        begin
          mode_d = dhbdc_pkg::MD_RUN;
          mcnt_d = '0;
        end
        else if (mcnt_q == SLEEP_LAST)
        begin
          mode_d = dhbdc_pkg::MD_SLEEP;
        end
      end
    endcase
  end

  // mode state, undervoltage reset clears everything including parallel mode
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= dhbdc_pkg::MD_SLEEP;
      mcnt_q <= '0;
      parallel_q <= 1'b0;
      tsd_q <= 1'b0;
      tsd_dly_q <= 1'b0;
    end
    else if (clk_en)
    begin
      mode_q <= mode_d;
      mcnt_q <= mcnt_d;
      parallel_q <= parallel_d;
      tsd_q <= thermal_shutdown;
      tsd_dly_q <= tsd_q;
    end
  end

  // per-bridge command, chopping and overcurrent state
  for (genvar gb = 0; gb < dhbdc_pkg::NUM_BR; gb++)
  begin : g_br
    logic driving;
    logic limit;
    assign driving = (cmd_q[gb] == dhbdc_pkg::CM_FWD) | (cmd_q[gb] == dhbdc_pkg::CM_REV);
    assign limit = fet_limit_high[gb] | fet_limit_low[gb];

    always_comb
    begin
      cmd_d[gb] = hold[gb] ? cmd_q[gb] : cmd_in[gb];
      chop_d[gb] = chop_q[gb];
      tmr_d[gb] = tmr_q[gb] + W'(1);
      unique case (chop_q[gb])
        dhbdc_pkg::CH_ON:
        begin
          if (!driving || br_off[gb])
          begin
            tmr_d[gb] = '0;
          end
          else if (tmr_q[gb] < BLANK_CYC)
          begin
            tmr_d[gb] = tmr_q[gb] + W'(1);
          end
          else
          begin
            tmr_d[gb] = tmr_q[gb];
            if (trip_eff[gb] && chop_en_q)
            begin
              chop_d[gb] = dhbdc_pkg::CH_FAST;
              tmr_d[gb] = '0;
            end
          end
        end
        dhbdc_pkg::CH_FAST:
        begin
          if (tmr_q[gb] == FAST_LAST)
          begin
            chop_d[gb] = dhbdc_pkg::CH_SLOW;
          end
          else if (current_near_zero[gb])
          begin
            chop_d[gb] = dhbdc_pkg::CH_OFFZ;
          end
        end
        dhbdc_pkg::CH_OFFZ:
        begin
          if (tmr_q[gb] == FAST_LAST)
          begin
            chop_d[gb] = dhbdc_pkg::CH_SLOW;
          end
        end
        dhbdc_pkg::CH_SLOW:
        begin
          if (tmr_q[gb] == OFF_LAST)
          begin
            chop_d[gb] = dhbdc_pkg::CH_ON;
            tmr_d[gb] = '0;
          end
        end
      endcase
      // a new command or a stop restarts with a fresh blanking window
      if (cmd_d[gb] != cmd_q[gb] || br_off[gb])
      begin
        chop_d[gb] = dhbdc_pkg::CH_ON;
        tmr_d[gb] = '0;
      end
    end

    // overcurrent deglitch and retry
    always_comb
    begin
      ocp_d[gb] = ocp_q[gb];
      ocnt_d[gb] = ocnt_q[gb] + W'(1);
      if (ocp_q[gb])
      begin
        if (ocnt_q[gb] == RETRY_LAST)
        begin
          ocp_d[gb] = 1'b0;
          ocnt_d[gb] = '0;
        end
      end
      else if (!limit)
      begin
        ocnt_d[gb] = '0;
      end
      else if (ocnt_q[gb] == DEG_LAST)
      begin
        ocp_d[gb] = 1'b1;
        ocnt_d[gb] = '0;
      end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
      if (rst)
      begin
        cmd_q[gb] <= dhbdc_pkg::CM_COAST;
        chop_q[gb] <= dhbdc_pkg::CH_ON;
        tmr_q[gb] <= '0;
        ocp_q[gb] <= 1'b0;
        ocnt_q[gb] <= '0;
      end
      else if (clk_en)
      begin
        cmd_q[gb] <= cmd_d[gb];
        chop_q[gb] <= chop_d[gb];
        tmr_q[gb] <= tmr_d[gb];
        ocp_q[gb] <= ocp_d[gb];
        ocnt_q[gb] <= ocnt_d[gb];
      end
    end

    // pin pattern: parallel mode takes bridge b state for both bridges
    assign out_d[gb] = br_off[gb] ? '{first: dhbdc_pkg::PIN_Z, second: dhbdc_pkg::PIN_Z} :
                       parallel_q ? dhbdc_pkg::drive(cmd_q[dhbdc_pkg::BR_B],
                                                     chop_q[dhbdc_pkg::BR_B]) :
                       dhbdc_pkg::drive(cmd_q[gb], chop_q[gb]);
  end

  // registered pins
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bridge_a_out <= '{first: dhbdc_pkg::PIN_Z, second: dhbdc_pkg::PIN_Z};
      bridge_b_out <= '{first: dhbdc_pkg::PIN_Z, second: dhbdc_pkg::PIN_Z};
      error_indicator_n <= dhbdc_pkg::PIN_L;
      internal_regulator_en <= 1'b0;
    end
    else if (clk_en)
    begin
      bridge_a_out <= out_d[dhbdc_pkg::BR_A];
      bridge_b_out <= out_d[dhbdc_pkg::BR_B];
      error_indicator_n <= fault_any ? dhbdc_pkg::PIN_L : dhbdc_pkg::PIN_Z;
      internal_regulator_en <= (mode_d != dhbdc_pkg::MD_SLEEP);
    end
  end

  // wishbone register port
  logic wb_hit;
  logic ctrl_wr;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign ctrl_wr = wb_hit & wb_we_i & wb_sel_i[0] & (wb_adr_i == dhbdc_pkg::REG_CTRL);
  always_comb
  begin
    status_word = '0;
    status_word[dhbdc_pkg::STS_PARALLEL] = parallel_q;
    status_word[dhbdc_pkg::STS_AWAKE] = (mode_q == dhbdc_pkg::MD_RUN);
    status_word[dhbdc_pkg::STS_SLEEP] = (mode_q == dhbdc_pkg::MD_SLEEP);
    status_word[dhbdc_pkg::STS_OCP_A] = ocp_q[dhbdc_pkg::BR_A];
    status_word[dhbdc_pkg::STS_OCP_B] = ocp_q[dhbdc_pkg::BR_B];
    status_word[dhbdc_pkg::STS_TSD] = tsd_q;
    status_word[dhbdc_pkg::STS_FAULT] = fault_any;
  end
  assign rd_word = (wb_adr_i == dhbdc_pkg::REG_CTRL) ? {31'h0000_0000, chop_en_q} :
                   (wb_adr_i == dhbdc_pkg::REG_STATUS) ? status_word : 32'h0000_0000;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      chop_en_q <= dhbdc_pkg::CTRL_CHOP_EN_RST;
    end
    else if (clk_en)
    begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? rd_word : 32'h0000_0000;
      if (ctrl_wr)
      begin
        chop_en_q <= wb_dat_i[dhbdc_pkg::CTRL_CHOP_EN];
      end
    end
  end
endmodule : dhbdc_top

/* dhbdc_pkg.sv */
// constants, enums, structs and helper functions for the dual bridge drive control
// assumes a 200 MHz system clock and a classic wishbone register port
// Function
// - inputs decode to coast, reverse, forward, brake
// - bridge a high-z input holds previous drive
// - bridge a high-z is a third level
// - both a inputs high-z at wake selects parallel
// - parallel mode: bridge b inputs drive both bridges
// - parallel mode ends only at next wake; undervoltage reset also clears it
// - chop trip turns drive off for off-time
// - blanking ignores trip, sets minimum on-time
// - comparator trip input feeds chopping logic
// - off period: 25% fast, 75% slow decay
// - fast decay reverses drive, zero current disables
// - slow decay: both low sides on
// - persistent limit disables bridge, retries later
// - overcurrent per bridge, high and low sides
// - thermal shutdown disables, auto resumes, then releases
// - undervoltage resets all logic, holds fault low
// - faults disable bridges, fault pin unlatched
// - sleep after entry delay, regulator off, z
// - wake automatically, outputs wait wake delay
// - chop off-time is 20 us
// - blanking time is 1.8 us
package dhbdc_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CHOP_OFF_NS = 20000;
  localparam int SENSE_BLANK_NS = 1800;
  localparam int OCP_DEGLITCH_NS = 2800;
  localparam int OCP_RETRY_US = 1600;
  localparam int SLEEP_ENTRY_US = 1;
  localparam int WAKE_UP_US = 1;
  localparam int FAST_PERCENT = 25;
  localparam int CHOP_OFF_CYC = (CHOP_OFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CHOP_FAST_CYC = CHOP_OFF_CYC * FAST_PERCENT / 100;
  localparam int SENSE_BLANK_CYC = (SENSE_BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OCP_DEG_CYC = (OCP_DEGLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OCP_RETRY_CYC = (OCP_RETRY_US * 1000000) / CLK_PERIOD_PS;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_US * 1000000) / CLK_PERIOD_PS;
  localparam int WAKE_UP_CYC = (WAKE_UP_US * 1000000) / CLK_PERIOD_PS;
  localparam int CNT_W = 20;
  // register map
  localparam int WB_ADR_W = 8;
  localparam logic [WB_ADR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [WB_ADR_W-1:0] REG_STATUS = 8'h04;
  localparam int CTRL_CHOP_EN = 0;
  localparam logic CTRL_CHOP_EN_RST = 1'b1;
  localparam int STS_PARALLEL = 0;
  localparam int STS_AWAKE = 1;
  localparam int STS_SLEEP = 2;
  localparam int STS_OCP_A = 3;
  localparam int STS_OCP_B = 4;
  localparam int STS_TSD = 5;
  localparam int STS_FAULT = 6;
  localparam int NUM_BR = 2;
  localparam int BR_A = 0;
  localparam int BR_B = 1;

  typedef enum logic [1:0] {MD_SLEEP, MD_WAKE, MD_RUN, MD_DOZE} dhbdc_mode_e;
  typedef enum logic [1:0] {CM_COAST, CM_REV, CM_FWD, CM_BRAKE} dhbdc_cmd_e;
  typedef enum logic [1:0] {CH_ON, CH_FAST, CH_OFFZ, CH_SLOW} dhbdc_chop_e;

  typedef struct packed {logic en; logic lvl;} dhbdc_pin_s;
  typedef struct packed {logic hiz; logic lvl;} dhbdc_tri_s;
  typedef struct packed {dhbdc_pin_s first; dhbdc_pin_s second;} dhbdc_bridge_s;

  localparam dhbdc_pin_s PIN_Z = '{en: 1'b0, lvl: 1'b0};
  localparam dhbdc_pin_s PIN_L = '{en: 1'b1, lvl: 1'b0};
  localparam dhbdc_pin_s PIN_H = '{en: 1'b1, lvl: 1'b1};

  // two logic inputs to a bridge command
  function automatic dhbdc_cmd_e decode(input logic first, input logic second);
    return dhbdc_cmd_e'({first, second} == 2'h3 ? 2'h3 : {first, second} == 2'h2 ? 2'h2 :
                        {first, second} == 2'h1 ? 2'h1 : 2'h0);
  endfunction : decode

  // pin pattern for a command in a given chopping phase
  function automatic dhbdc_bridge_s drive(input dhbdc_cmd_e cmd, input dhbdc_chop_e ph);
    dhbdc_bridge_s r;
    r = '{first: PIN_Z, second: PIN_Z};
    unique case (ph)
      CH_ON:
      begin
        unique case (cmd)
          CM_COAST: r = '{first: PIN_Z, second: PIN_Z};
          CM_REV: r = '{first: PIN_L, second: PIN_H};
          CM_FWD: r = '{first: PIN_H, second: PIN_L};
          CM_BRAKE: r = '{first: PIN_L, second: PIN_L};
        endcase
      end
      CH_FAST: r = (cmd == CM_FWD) ? '{first: PIN_L, second: PIN_H} :
                                      '{first: PIN_H, second: PIN_L};
      CH_OFFZ: r = '{first: PIN_Z, second: PIN_Z};
      CH_SLOW: r = '{first: PIN_L, second: PIN_L};
    endcase
    return r;
  endfunction : drive
endpackage : dhbdc_pkg

/* dhbdc_assertions.sv */
// checker for the pin behaviour of the dual bridge drive control
// assumes clk_en high and the short retry and sleep counts of the bench
`timescale 1ns/10ps
module dhbdc_checker #(
  parameter int OCP_RETRY_CYC = 50,
  parameter int SLEEP_ENTRY_CYC = 5
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sleep_ctrl_n,
  input wire logic bridge_b_in_first,
  input wire logic bridge_b_in_second,
  input wire logic [1:0] chop_trip,
  input wire logic [1:0] fet_limit_high,
  input wire logic [1:0] fet_limit_low,
  input wire logic thermal_shutdown,
  input wire dhbdc_pkg::dhbdc_bridge_s bridge_a_out,
  input wire dhbdc_pkg::dhbdc_bridge_s bridge_b_out,
  input wire dhbdc_pkg::dhbdc_pin_s error_indicator_n,
  input wire logic internal_regulator_en,
  input wire logic wb_ack_o
);
  localparam int QUIET = 4100;
  localparam int OCP_HOLD = 570;
  logic [12:0] quiet_q;
  logic [9:0] ocp_q;
  logic [9:0] free_q;
  logic [5:0] slp_q;
  logic [1:0] b_q;
  wire logic calm = !thermal_shutdown && (fet_limit_high | fet_limit_low) == 2'h0;
  wire logic b_on = bridge_b_in_first | bridge_b_in_second;
  wire logic [1:0] b_in = {bridge_b_in_first, bridge_b_in_second};
  wire logic still = calm && sleep_ctrl_n && chop_trip == 2'h0 && b_q == b_in;
  wire dhbdc_pkg::dhbdc_bridge_s b_exp = {b_on, b_in == 2'h2, b_on, b_in == 2'h1};
  // saturating counts of how long each condition has held
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      quiet_q <= '0;
      ocp_q <= '0;
      free_q <= '0;
      slp_q <= '0;
      b_q <= '0;
    end
    else
    begin
      b_q <= b_in;
      quiet_q <= still ? quiet_q + 13'(quiet_q < 13'(QUIET)) : '0;
      ocp_q <= fet_limit_high[1] ? ocp_q + 10'(ocp_q <= 10'(OCP_HOLD)) : '0;
      free_q <= calm ? free_q + 10'(free_q < 10'(OCP_RETRY_CYC + 20)) : '0;
      slp_q <= !sleep_ctrl_n ? slp_q + 6'(slp_q < 6'(SLEEP_ENTRY_CYC + 6)) : '0;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_all_z;
    !bridge_a_out.first.en && !bridge_a_out.second.en
      && !bridge_b_out.first.en && !bridge_b_out.second.en;
  endsequence
  sequence s_wake_start;
    $rose(sleep_ctrl_n) && !internal_regulator_en;
  endsequence
  a_decode_b: assert property (quiet_q == QUIET |-> bridge_b_out == b_exp)
    else $error("bridge b pins differ from decoded command");
  a_tsd_off: assert property (thermal_shutdown [*4] |-> s_all_z ##0 error_indicator_n.en)
    else $error("over temperature left a bridge driving");
  a_ocp_b_off: assert property (ocp_q == 10'(OCP_HOLD) |-> !bridge_b_out.first.en
    && !bridge_b_out.second.en && error_indicator_n.en)
    else $error("held current limit did not stop bridge b");
  a_fault_free: assert property (free_q == 10'(OCP_RETRY_CYC + 20) |-> !error_indicator_n.en)
    else $error("fault pin still low with no fault");
  a_sleep_in: assert property (slp_q == 6'(SLEEP_ENTRY_CYC + 6) |-> !internal_regulator_en)
    else $error("regulator still on after sleep delay");
  a_sleep_z: assert property (!internal_regulator_en |-> s_all_z)
    else $error("pins driven while regulator off");
  a_wake_hold: assert property (s_wake_start |-> s_all_z [*4])
    else $error("pins changed before wake delay");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule : dhbdc_checker
bind dhbdc_top dhbdc_checker #(.OCP_RETRY_CYC(OCP_RETRY_CYC), .SLEEP_ENTRY_CYC(SLEEP_ENTRY_CYC))
  u_dhbdc_checker (.sys_clk, .rst, .sleep_ctrl_n, .bridge_b_in_first, .bridge_b_in_second,
  .chop_trip, .fet_limit_high, .fet_limit_low, .thermal_shutdown, .bridge_a_out,
  .bridge_b_out, .error_indicator_n, .internal_regulator_en, .wb_ack_o);

/* dhbdc_host.sv */
// host model: drives bridge and sleep inputs the way a controller would
// assumes bench requests change just after a rising edge
`timescale 1ns/10ps
module dhbdc_host (
  input wire logic sys_clk,
  input wire logic [1:0] a_cmd,
  input wire logic [1:0] a_float,
  input wire logic [1:0] b_cmd,
  input wire logic awake,
  output dhbdc_pkg::dhbdc_tri_s bridge_a_in_first,
  output dhbdc_pkg::dhbdc_tri_s bridge_a_in_second,
  output logic bridge_b_in_first,
  output logic bridge_b_in_second,
  output logic sleep_ctrl_n
);
  // start driven low and awake
  initial
  begin
    bridge_a_in_first = '{hiz: 1'b0, lvl: 1'b0};
    bridge_a_in_second = '{hiz: 1'b0, lvl: 1'b0};
    bridge_b_in_first = 1'b0;
    bridge_b_in_second = 1'b0;
    sleep_ctrl_n = 1'b1;
  end
  // a floating pin has no driven level, so lvl toggles every cycle while its a_cmd bit is low and holds while it is high
  always @(posedge sys_clk)
  begin
    bridge_a_in_first <= '{hiz: a_float[1], lvl: a_float[1] ^ a_cmd[1] ^ bridge_a_in_first.lvl & a_float[1]};
    bridge_a_in_second <= '{hiz: a_float[0], lvl: a_float[0] ^ a_cmd[0] ^ bridge_a_in_second.lvl & a_float[0]};
    bridge_b_in_first <= b_cmd[1];
    bridge_b_in_second <= b_cmd[0];
    sleep_ctrl_n <= awake;
  end
endmodule : dhbdc_host

/* dhbdc_tb.sv */
// testbench: scenario tasks for the dual bridge drive control
// assumes the checker is bound to the top module; clk_en stays high
`timescale 1ns/10ps
module testbench;
  localparam int RETRY = 50;
  localparam int SLP = 5;
  localparam int WAKE = 5;
  localparam dhbdc_pkg::dhbdc_bridge_s ZZ = '{dhbdc_pkg::PIN_Z, dhbdc_pkg::PIN_Z};
  localparam dhbdc_pkg::dhbdc_bridge_s REV = '{dhbdc_pkg::PIN_L, dhbdc_pkg::PIN_H};
  localparam dhbdc_pkg::dhbdc_bridge_s FWD = '{dhbdc_pkg::PIN_H, dhbdc_pkg::PIN_L};
  localparam dhbdc_pkg::dhbdc_bridge_s BRK = '{dhbdc_pkg::PIN_L, dhbdc_pkg::PIN_L};
  localparam dhbdc_pkg::dhbdc_bridge_s DEC [4] = '{ZZ, REV, FWD, BRK};
  logic sys_clk, rst, awake, thermal_shutdown, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [1:0] a_cmd, a_float, b_cmd, chop_trip, current_near_zero, fet_limit_high, fet_limit_low;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  dhbdc_pkg::dhbdc_tri_s bridge_a_in_first, bridge_a_in_second;
  logic bridge_b_in_first, bridge_b_in_second, sleep_ctrl_n, internal_regulator_en;
  dhbdc_pkg::dhbdc_bridge_s bridge_a_out, bridge_b_out;
  dhbdc_pkg::dhbdc_pin_s error_indicator_n;
  int fail_count, n_checks;
  dhbdc_host u_dhbdc_host (.sys_clk, .a_cmd, .a_float, .b_cmd, .awake, .bridge_a_in_first,
    .bridge_a_in_second, .bridge_b_in_first, .bridge_b_in_second, .sleep_ctrl_n);
  dhbdc_top #(.OCP_RETRY_CYC(RETRY), .SLEEP_ENTRY_CYC(SLP), .WAKE_UP_CYC(WAKE)) u_dhbdc_top (
    .sys_clk, .rst, .clk_en(1'b1), .bridge_a_in_first, .bridge_a_in_second, .bridge_b_in_first,
    .bridge_b_in_second, .sleep_ctrl_n, .chop_trip, .current_near_zero, .fet_limit_high,
    .fet_limit_low, .thermal_shutdown, .bridge_a_out, .bridge_b_out, .error_indicator_n,
    .internal_regulator_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o);
  // clock at 200 MHz
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chkb(input string what, input dhbdc_pkg::dhbdc_bridge_s exp, input dhbdc_pkg::dhbdc_bridge_s got);
    chk(what, 32'(exp), 32'(got));
  endtask : chkb
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  // count cycles until bridge b shows a pattern
  task automatic wait_b(input dhbdc_pkg::dhbdc_bridge_s pat, input int bound, output int n);
    n = 0;
    while (bridge_b_out !== pat && n < bound)
    begin
      cyc(1);
      n++;
    end
    if (n >= bound)
    begin
      chkb("wait bridge b", pat, bridge_b_out);
      close_out();
    end
  endtask : wait_b
  // one classic wishbone cycle, released at the edge that samples ack
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc(1);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do
    begin
      cyc(1);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20)
    begin
      chk("wishbone ack", 32'h0000_0001, 32'(wb_ack_o));
      close_out();
    end
  endtask : wb
  task automatic s_regs();
    wb(1'b0, dhbdc_pkg::REG_CTRL, 32'h0000_0000, rd);
    chk("ctrl reset", 32'h0000_0001, rd);
    wb(1'b1, dhbdc_pkg::REG_CTRL, 32'h0000_0000, rd);
    wb(1'b0, dhbdc_pkg::REG_CTRL, 32'h0000_0000, rd);
    chk("ctrl written", 32'h0000_0000, rd);
    wb(1'b1, dhbdc_pkg::REG_CTRL, 32'h0000_0001, rd);
    wb(1'b1, 8'h08, 32'hffff_ffff, rd);
    wb(1'b0, 8'h08, 32'h0000_0000, rd);
    chk("unmapped", 32'h0000_0000, rd);
    wb(1'b0, dhbdc_pkg::REG_STATUS, 32'h0000_0000, rd);
    chk("status running", 32'h0000_0002, rd);
  endtask : s_regs
  task automatic s_decode();
    for (int i = 0; i < 4; i++)
    begin
      a_cmd <= 2'(i);
      b_cmd <= 2'(i);
      cyc(5);
      chkb("bridge a", DEC[i], bridge_a_out);
      chkb("bridge b", DEC[i], bridge_b_out);
    end
    a_float <= 2'b01;
    a_cmd <= 2'b10;
    cyc(5);
    chkb("a held", BRK, bridge_a_out);
    a_float <= 2'b10;
    a_cmd <= 2'b01;
    cyc(5);
    chkb("a held", BRK, bridge_a_out);
    a_float <= 2'b00;
    b_cmd <= 2'b10;
    cyc(4110);
  endtask : s_decode
  task automatic s_chop();
    int f, s, o;
    chop_trip <= 2'b10;
    wait_b(REV, 800, o);
    chop_trip <= 2'b00;
    wait_b(BRK, 1100, f);
    chk("fast time", 32'h0000_0001, 32'(f >= dhbdc_pkg::CHOP_FAST_CYC - 2 && f <= dhbdc_pkg::CHOP_FAST_CYC + 2));
    wait_b(FWD, 3200, s);
    chk("off time", 32'h0000_0001, 32'(f + s >= dhbdc_pkg::CHOP_OFF_CYC - 3 && f + s <= dhbdc_pkg::CHOP_OFF_CYC + 3));
    chop_trip <= 2'b10;
    wait_b(REV, 800, o);
    chk("on time", 32'h0000_0001, 32'(o >= dhbdc_pkg::SENSE_BLANK_CYC - 2 && o <= dhbdc_pkg::SENSE_BLANK_CYC + 4));
    current_near_zero <= 2'b10;
    chop_trip <= 2'b00;
    wait_b(ZZ, 4, o);
    current_near_zero <= 2'b00;
    wait_b(FWD, 4100, o);
    wb(1'b1, dhbdc_pkg::REG_CTRL, 32'h0000_0000, rd);
    chop_trip <= 2'b10;
    cyc(400);
    chkb("no chop", FWD, bridge_b_out);
    chop_trip <= 2'b00;
    wb(1'b1, dhbdc_pkg::REG_CTRL, 32'h0000_0001, rd);
  endtask : s_chop
  task automatic s_ocp();
    int n;
    fet_limit_high <= 2'b10;
    cyc(580);
    chkb("b stopped", ZZ, bridge_b_out);
    chkb("a still drives", REV, bridge_a_out);
    chk("ocp pin", 32'h0000_0001, 32'(error_indicator_n.en));
    fet_limit_high <= 2'b00;
    wait_b(FWD, RETRY + 20, n);
    cyc(3);
    chk("ocp pin cleared", 32'h0000_0000, 32'(error_indicator_n.en));
    fet_limit_low <= 2'b01;
    cyc(580);
    chkb("a stopped", ZZ, bridge_a_out);
    chkb("b still drives", FWD, bridge_b_out);
    fet_limit_low <= 2'b00;
    cyc(RETRY + 10);
    chkb("a resumed", REV, bridge_a_out);
  endtask : s_ocp
  task automatic s_tsd();
    int n;
    thermal_shutdown <= 1'b1;
    cyc(5);
    chkb("tsd a", ZZ, bridge_a_out);
    chk("tsd pin", 32'h0000_0001, 32'(error_indicator_n.en));
    thermal_shutdown <= 1'b0;
    wait_b(FWD, 10, n);
    chk("pin at resume", 32'h0000_0001, 32'(error_indicator_n.en));
    cyc(3);
    chk("pin released", 32'h0000_0000, 32'(error_indicator_n.en));
  endtask : s_tsd
  task automatic s_sleep();
    a_float <= 2'b11;
    awake <= 1'b0;
    cyc(SLP + 8);
    chk("regulator off", 32'h0000_0000, 32'(internal_regulator_en));
    chkb("sleep b", ZZ, bridge_b_out);
    awake <= 1'b1;
    b_cmd <= 2'b01;
    cyc(WAKE);
    chkb("wake hold", ZZ, bridge_b_out);
    cyc(10);
    chkb("parallel a", REV, bridge_a_out);
    chkb("parallel b", REV, bridge_b_out);
    wb(1'b0, dhbdc_pkg::REG_STATUS, 32'h0000_0000, rd);
    chk("status parallel", 32'h0000_0003, rd);
    a_float <= 2'b00;
    a_cmd <= 2'b10;
    cyc(6);
    chkb("still parallel", REV, bridge_a_out);
    awake <= 1'b0;
    cyc(SLP + 8);
    awake <= 1'b1;
    cyc(WAKE + 10);
    chkb("parallel left", FWD, bridge_a_out);
  endtask : s_sleep
  task automatic s_supply_undervoltage_lockout();
    rst <= 1'b1;
    cyc(2);
    chk("supply_undervoltage_lockout pin", 32'h0000_0001, 32'(error_indicator_n.en));
    chk("supply_undervoltage_lockout regulator", 32'h0000_0000, 32'(internal_regulator_en));
    chkb("supply_undervoltage_lockout a", ZZ, bridge_a_out);
    rst <= 1'b0;
    cyc(WAKE + 10);
    chk("pin after supply_undervoltage_lockout", 32'h0000_0000, 32'(error_indicator_n.en));
    chkb("b after supply_undervoltage_lockout", REV, bridge_b_out);
  endtask : s_supply_undervoltage_lockout
  // reset, then the scenarios in turn
  initial
  begin
    {rst, awake} = 2'b11;
    {thermal_shutdown, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
    {a_cmd, a_float, b_cmd, chop_trip, current_near_zero, fet_limit_high, fet_limit_low} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {fail_count, n_checks} = '0;
    cyc(16);
    rst <= 1'b0;
    cyc(WAKE + 10);
    s_regs();
    s_decode();
    s_chop();
    s_ocp();
    s_tsd();
    s_sleep();
    s_supply_undervoltage_lockout();
    close_out();
  end
endmodule : testbench
